//--- verilog/elv_ctrl.sv
// run mode, call service and door sequencing for one elevator car
`timescale 1ns/10ps
`include "elv_consts.svh"
module elv_ctrl
  import elv_pkg::*;
#(
  parameter int N_FLOORS = `ELV_N_FLOORS,
  parameter int unsigned TICK_CYCLES = `ELV_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // mode selectors and inspection buttons
  input wire elv_sel_t sel,
  input wire elv_insp_t insp,
  // call and panel buttons
  input wire logic [N_FLOORS-1:0] car_btn,
  input wire logic [N_FLOORS-1:0] hall_up_btn,
  input wire logic [N_FLOORS-1:0] hall_dn_btn,
  input wire logic close_btn,
  input wire logic bypass_btn,
  // car position and load
  input wire logic [((N_FLOORS > 1) ? $clog2(N_FLOORS) : 1)-1:0] current_floor,
  input wire logic level_zone,
  input wire logic overload,
  input wire logic full_load,
  // door operator feedback
  input wire elv_door_fb_t door_fb,
  // holding time T in 100 ms steps
  input wire logic [7:0] hold_time_ds,
  // mode and commands
  output elv_mode_t mode,
  output elv_door_t door,
  output elv_drive_t drive,
  output elv_ovl_t ovl,
  output logic dir_up,
  // registered call lamps
  output logic [N_FLOORS-1:0] car_call_lamp,
  output logic [N_FLOORS-1:0] hall_up_lamp,
  output logic [N_FLOORS-1:0] hall_dn_lamp
);
  localparam int FW = (N_FLOORS > 1) ? $clog2(N_FLOORS) : 1;
  localparam int HW = `ELV_HOLD_W;
  localparam logic [FW-1:0] TOP_FLOOR = FW'(N_FLOORS - 1);
  localparam logic [HW-1:0] HOLD_ADJ = HW'(`ELV_HOLD_ADJ_TICKS);

  typedef struct packed {
    elv_state_t st;
    elv_mode_t mode;
    logic dir_up;
    logic left_zone;
    logic srv_hall;
    logic srv_car;
    logic [HW-1:0] hold_cnt;
    logic [N_FLOORS-1:0] car_call;
    logic [N_FLOORS-1:0] hall_up;
    logic [N_FLOORS-1:0] hall_dn;
    elv_door_t door;
    elv_drive_t drive;
    elv_ovl_t ovl;
  } elv_ctrl_state_t;

  elv_ctrl_state_t s, next_s;
  logic tick;
  logic [N_FLOORS-1:0] above_m, below_m, here_m;
  logic insp_active, iu, id, ign_hall;
  logic [N_FLOORS-1:0] hu, hd, any_call, clr_car, clr_up, clr_dn;
  logic calls_above, calls_below, term_top, term_bot;
  logic here_car, here_hall, stop_here, serve_up, serve_dn;
  logic [HW-1:0] base, hold_load;

  elv_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick) // RQ19
  );

  // floor masks relative to the car
  for (genvar f = 0; f < N_FLOORS; f++) begin : g_floor
    localparam logic [FW-1:0] FI = FW'(f);
    assign above_m[f] = FI > current_floor;
    assign below_m[f] = FI < current_floor;
    assign here_m[f] = FI == current_floor;
  end

  // hold time chosen from what the stop served
  always_comb begin
    base = {1'b0, hold_time_ds};
    hold_load = base;
    if (s.srv_hall && !s.srv_car) begin
      // never below one tick, so a short T still gives a visible hold
      hold_load = (base > HOLD_ADJ) ? base - HOLD_ADJ : HW'(1); // RQ4
    end else if (s.srv_hall && s.srv_car) begin
      hold_load = base + HOLD_ADJ; // RQ5
    end
  end

  always_comb begin
    next_s = s;
    // highest priority selector in inspection owns the buttons
    insp_active = !sel.top_auto || !sel.car_auto || !sel.cab_auto;
    if (!sel.top_auto) begin // RQ12
      iu = insp.top_up;
      id = insp.top_dn;
    end else if (!sel.car_auto) begin
      iu = insp.car_up;
      id = insp.car_dn;
    end else begin
      iu = insp.cab_up;
      id = insp.cab_dn;
    end
    if (insp_active) begin
      next_s.mode = ELV_MODE_INSP;
    end else if (sel.attend) begin
      next_s.mode = ELV_MODE_ATTEND; // RQ10
    end else begin
      next_s.mode = ELV_MODE_AUTO; // RQ1
    end

    // landing calls stay latched but are not served
    ign_hall = full_load || (s.mode == ELV_MODE_ATTEND && bypass_btn); // RQ17 RQ18
    hu = ign_hall ? '0 : s.hall_up;
    hd = ign_hall ? '0 : s.hall_dn;
    any_call = s.car_call | hu | hd;
    calls_above = |(any_call & above_m);
    calls_below = |(any_call & below_m);
    term_top = current_floor == TOP_FLOOR;
    term_bot = current_floor == '0;
    here_car = |(s.car_call & here_m);
    here_hall = |((hu | hd) & here_m);
    // a car with nothing ahead takes whatever waits at this floor
    serve_up = s.dir_up || term_bot || !calls_below; // RQ8 RQ9
    serve_dn = !s.dir_up || term_top || !calls_above; // RQ8 RQ9
    stop_here = here_car || |(here_m & ((serve_up ? hu : '0) | (serve_dn ? hd : '0)));
    if (s.dir_up ? !calls_above : !calls_below) begin
      stop_here = 1'b1;
    end
    clr_car = '0;
    clr_up = '0;
    clr_dn = '0;

    unique case (s.st)
      ST_PWRUP: begin
        next_s.st = level_zone ? ST_OPENING : ST_IDLE; // RQ13
      end
      ST_IDLE: begin
        if (overload || here_car || here_hall) begin
          next_s.st = ST_OPENING; // RQ14 RQ16
          next_s.srv_hall = 1'b0;
          next_s.srv_car = 1'b0;
          clr_car = here_m;
          clr_up = ign_hall ? '0 : here_m;
          clr_dn = ign_hall ? '0 : here_m;
        end else if (calls_above || calls_below) begin
          next_s.st = ST_RUN;
          next_s.left_zone = 1'b0;
          next_s.dir_up = calls_above && (s.dir_up || !calls_below);
        end
      end
      ST_RUN: begin
        if (!level_zone) begin
          next_s.left_zone = 1'b1;
        end
        // the zone we start from does not count as an arrival
        if (level_zone && s.left_zone && stop_here) begin
          next_s.st = ST_OPENING; // RQ2
          next_s.srv_car = here_car;
          next_s.srv_hall = |(here_m & ((serve_up ? hu : '0) | (serve_dn ? hd : '0)));
          clr_car = here_m;
          clr_up = (serve_up && !ign_hall) ? here_m : '0;
          clr_dn = (serve_dn && !ign_hall) ? here_m : '0;
        end
        // calls behind the travel direction are wrong calls
        clr_car = clr_car | (s.dir_up ? below_m : above_m); // RQ7
      end
      ST_OPENING: begin
        if (door_fb.open_lim) begin
          next_s.st = ST_HOLD;
          next_s.hold_cnt = hold_load;
        end
      end
      ST_HOLD: begin
        if (overload || door_fb.safety_edge) begin
          next_s.hold_cnt = hold_load; // RQ16
        end else if (close_btn) begin
          next_s.st = ST_CLOSING; // RQ6
        end else if (s.mode == ELV_MODE_AUTO && tick) begin // RQ19
          if (s.hold_cnt <= HW'(1)) begin
            next_s.st = ST_CLOSING; // RQ3
          end else begin
            next_s.hold_cnt = s.hold_cnt - HW'(1);
          end
        end
      end
      ST_CLOSING: begin
        if (door_fb.safety_edge || overload) begin
          next_s.st = ST_OPENING; // RQ15 RQ16
        end else if (here_hall) begin
          next_s.st = ST_OPENING; // RQ14
          next_s.srv_hall = 1'b0;
          next_s.srv_car = 1'b0;
          clr_up = here_m;
          clr_dn = here_m;
        end else if (door_fb.close_lim) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_INSP: begin
        next_s.st = ST_IDLE;
      end
    endcase
    if (insp_active) begin
      next_s.st = ST_INSP; // RQ11
    end

    // a press in the same cycle as a clear keeps the call
    next_s.car_call = (s.car_call & ~clr_car) | car_btn; // RQ7
    next_s.hall_up = (s.hall_up & ~clr_up) | hall_up_btn;
    next_s.hall_dn = (s.hall_dn & ~clr_dn) | hall_dn_btn;

    next_s.door.open = next_s.st == ST_OPENING;
    next_s.door.close = next_s.st == ST_CLOSING;
    next_s.drive.up = (next_s.st == ST_RUN && next_s.dir_up && !overload) ||
                      (next_s.st == ST_INSP && iu && !id); // RQ11 RQ16
    next_s.drive.dn = (next_s.st == ST_RUN && !next_s.dir_up && !overload) ||
                      (next_s.st == ST_INSP && id && !iu); // RQ11 RQ16
    next_s.drive.insp_speed = next_s.st == ST_INSP;
    next_s.ovl.lamp = overload; // RQ16
    next_s.ovl.buzzer = overload;
    next_s.ovl.code = overload;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mode = s.mode;
  assign door = s.door;
  assign drive = s.drive;
  assign ovl = s.ovl;
  assign dir_up = s.dir_up;
  assign car_call_lamp = s.car_call;
  assign hall_up_lamp = s.hall_up;
  assign hall_dn_lamp = s.hall_dn;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_auto_sel;
    sel.top_auto && sel.car_auto && sel.cab_auto && !sel.attend |=> mode == ELV_MODE_AUTO;
  endproperty
  a_auto_sel: assert property (p_auto_sel) else $error("auto mode not selected"); // RQ1

  property p_attend_sel;
    sel.top_auto && sel.car_auto && sel.cab_auto && sel.attend |=> mode == ELV_MODE_ATTEND;
  endproperty
  a_attend_sel: assert property (p_attend_sel) else $error("attendant mode missed"); // RQ10

  property p_insp_prio;
    !sel.top_auto && insp.top_up && !insp.top_dn && insp.car_dn |=>
      drive.up && !drive.dn && drive.insp_speed;
  endproperty
  a_insp_prio: assert property (p_insp_prio) else $error("top selector lost priority"); // RQ12

  property p_insp_release;
    insp_active && !iu && !id |=> !drive.up && !drive.dn && mode == ELV_MODE_INSP;
  endproperty
  a_insp_release: assert property (p_insp_release) else $error("car moved on release"); // RQ11

  property p_close_btn;
    s.st == ST_HOLD && close_btn && !overload && !door_fb.safety_edge && !insp_active
      |=> door.close && !door.open;
  endproperty
  a_close_btn: assert property (p_close_btn) else $error("close button ignored"); // RQ6

  property p_safety_rev;
    s.st == ST_CLOSING && door_fb.safety_edge && !insp_active |=> door.open && !door.close;
  endproperty
  a_safety_rev: assert property (p_safety_rev) else $error("no reversal on edge"); // RQ15

  property p_ovl;
    overload && !insp_active |=> ovl.lamp && ovl.buzzer && ovl.code && !drive.up && !drive.dn;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload not handled"); // RQ16

  property p_attend_hold;
    s.mode == ELV_MODE_ATTEND && s.st == ST_HOLD && !close_btn && !insp_active |=> !door.close;
  endproperty
  a_attend_hold: assert property (p_attend_hold) else $error("attendant door closed"); // RQ10

  property p_hold_short;
    s.st == ST_OPENING && door_fb.open_lim && !insp_active && s.srv_hall && !s.srv_car &&
      hold_time_ds > 8'h14 |=> s.hold_cnt == {1'b0, $past(hold_time_ds)} - HOLD_ADJ;
  endproperty
  a_hold_short: assert property (p_hold_short) else $error("short hold wrong"); // RQ4

  property p_hold_long;
    s.st == ST_OPENING && door_fb.open_lim && !insp_active && s.srv_hall && s.srv_car
      |=> s.hold_cnt == {1'b0, $past(hold_time_ds)} + HOLD_ADJ;
  endproperty
  a_hold_long: assert property (p_hold_long) else $error("long hold wrong"); // RQ5

  property p_auto_close;
    s.st == ST_HOLD && s.mode == ELV_MODE_AUTO && tick && s.hold_cnt == HW'(1) &&
      !overload && !door_fb.safety_edge && !insp_active |=> door.close;
  endproperty
  a_auto_close: assert property (p_auto_close) else $error("no auto close"); // RQ3

  property p_pwrup;
    s.st == ST_PWRUP && level_zone && !insp_active |=> door.open;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("no open at power up"); // RQ13

  property p_stop_open;
    s.st == ST_RUN && level_zone && s.left_zone && here_car && !insp_active |=>
      door.open && !drive.up && !drive.dn;
  endproperty
  a_stop_open: assert property (p_stop_open) else $error("no open at stop"); // RQ2

  property p_wrong_call;
    s.st == ST_RUN && s.dir_up && car_btn == '0 && !insp_active |=>
      (car_call_lamp & $past(below_m)) == '0;
  endproperty
  a_wrong_call: assert property (p_wrong_call) else $error("wrong call kept"); // RQ7

  property p_full_skip;
    full_load && s.st == ST_IDLE && s.car_call == '0 && !overload && !insp_active |=>
      !drive.up && !drive.dn && !door.open;
  endproperty
  a_full_skip: assert property (p_full_skip) else $error("full load served hall"); // RQ17

  property p_bypass_skip;
    s.mode == ELV_MODE_ATTEND && bypass_btn && s.st == ST_IDLE && s.car_call == '0 &&
      !overload && !insp_active |=> !drive.up && !drive.dn && !door.open;
  endproperty
  a_bypass_skip: assert property (p_bypass_skip) else $error("bypass served hall"); // RQ18

  c_stop_open: cover property (s.st == ST_RUN ##1 s.st == ST_OPENING);
  c_auto_close: cover property (s.st == ST_HOLD && s.mode == ELV_MODE_AUTO ##1 door.close);
  c_reopen: cover property (s.st == ST_CLOSING && door_fb.safety_edge ##1 door.open);
  c_insp_run: cover property (drive.insp_speed && drive.up);
endmodule // elv_ctrl

//--- verilog/elv_consts.svh
// constants for the elevator run mode and door supervisor
`ifndef ELV_CONSTS_SVH
`define ELV_CONSTS_SVH
// Overview of operation
// RQ1: auto when inspection normal and selector auto
// RQ2: door opens by itself at every stop
// RQ3: auto mode closes after hold time
// RQ4: landing call only stop uses T minus 2s
// RQ5: landing and car call stop uses T plus 2s
// RQ6: close button starts closing at once
// RQ7: car calls latch, wrong calls cancelled
// RQ8: landing call stops car in same direction
// RQ9: terminal floors serve opposite landing calls
// RQ10: attendant mode closes only on close button
// RQ11: inspection runs only while button held
// RQ12: car top, car, cabinet selector priority order
// RQ13: power up in leveling zone opens door
// RQ14: own floor landing call reopens the door
// RQ15: safety edge reverses, close again when clear
// RQ16: overload holds door, lamp, buzzer, code, no run (inspection drive still runs under overload)
// RQ17: full load serves car calls only
// RQ18: attendant bypass serves car calls only
// RQ19: timers run from a fixed system tick
`define ELV_CLK_HZ 10000000
`define ELV_TICK_MS 100
`define ELV_TICK_CYCLES (`ELV_CLK_HZ / 1000 * `ELV_TICK_MS)
`define ELV_HOLD_ADJ_S 2
`define ELV_HOLD_ADJ_TICKS (`ELV_HOLD_ADJ_S * 1000 / `ELV_TICK_MS)
`define ELV_N_FLOORS 8
`define ELV_HOLD_W 9
`endif

//--- verilog/elv_pkg.sv
// types shared by the elevator supervisor modules
package elv_pkg;
  typedef enum logic [1:0] {ELV_MODE_AUTO, ELV_MODE_ATTEND, ELV_MODE_INSP} elv_mode_t;
  typedef enum logic [2:0] {
    ST_PWRUP, ST_IDLE, ST_RUN, ST_OPENING, ST_HOLD, ST_CLOSING, ST_INSP
  } elv_state_t;
  typedef struct packed {
    logic top_auto;
    logic car_auto;
    logic cab_auto;
    logic attend;
  } elv_sel_t;
  typedef struct packed {
    logic top_up;
    logic top_dn;
    logic car_up;
    logic car_dn;
    logic cab_up;
    logic cab_dn;
  } elv_insp_t;
  typedef struct packed {
    logic open_lim;
    logic close_lim;
    logic safety_edge;
  } elv_door_fb_t;
  typedef struct packed {
    logic open;
    logic close;
  } elv_door_t;
  typedef struct packed {
    logic up;
    logic dn;
    logic insp_speed;
  } elv_drive_t;
  typedef struct packed {
    logic lamp;
    logic buzzer;
    logic code;
  } elv_ovl_t;
endpackage

//--- verilog/elv_tick.sv
// fixed rate tick generator for the supervisor timers
`timescale 1ns/10ps
`include "elv_consts.svh"
module elv_tick #(
  parameter int unsigned TICK_CYCLES = `ELV_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // one cycle pulse every TICK_CYCLES
  output logic tick
);
  localparam int W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } elv_tick_state_t;
  elv_tick_state_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == LAST) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule // elv_tick

//--- sim/elv_door_model.sv
// door operator stand-in answering open and close commands
`timescale 1ns/10ps
module elv_door_model
  import elv_pkg::*;
#(
  parameter int TRAVEL = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // commands and obstruction
  input wire elv_door_t door,
  input wire logic edge_hit,
  // feedback
  output elv_door_fb_t door_fb
);
  int cnt;
  // a limit drops as soon as the door leaves it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      door_fb <= 3'h2;
    end else begin
      door_fb.safety_edge <= edge_hit;
      if (door.open && !door_fb.open_lim) begin
        door_fb.close_lim <= 1'b0;
        cnt <= (cnt == TRAVEL) ? 0 : cnt + 1;
        door_fb.open_lim <= (cnt == TRAVEL);
      end else if (door.close && !door_fb.close_lim) begin
        door_fb.open_lim <= 1'b0;
        cnt <= (cnt == TRAVEL) ? 0 : cnt + 1;
        door_fb.close_lim <= (cnt == TRAVEL);
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule // elv_door_model

//--- sim/testbench.sv
// self-checking bench for the elevator supervisor
`timescale 1ns/10ps
module testbench;
  import elv_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  elv_sel_t sel = 4'hE;
  elv_insp_t insp = 6'h00;
  logic [7:0] car_btn = 8'h00;
  logic [7:0] hall_up_btn = 8'h00;
  logic [7:0] hall_dn_btn = 8'h00;
  logic close_btn = 1'b0;
  logic bypass_btn = 1'b0;
  logic [2:0] current_floor = 3'h0;
  logic level_zone = 1'b1;
  logic overload = 1'b0;
  logic full_load = 1'b0;
  logic edge_hit = 1'b0;
  logic [7:0] hold_time_ds = 8'h04;
  elv_door_fb_t door_fb;
  elv_mode_t mode;
  elv_door_t door;
  elv_drive_t drive;
  elv_ovl_t ovl;
  logic dir_up;
  logic [7:0] car_call_lamp;
  logic [7:0] hall_up_lamp;
  logic [7:0] hall_dn_lamp;
  int mismatches = 0;
  int tests_run = 0;
  int n;

  always #50 clk_sys = ~clk_sys;

  // short tick keeps hold times to a few dozen cycles
  elv_ctrl #(.N_FLOORS(8), .TICK_CYCLES(4)) uut (.clk_sys, .rstn, .sel, .insp, .car_btn,
    .hall_up_btn, .hall_dn_btn, .close_btn, .bypass_btn, .current_floor, .level_zone,
    .overload, .full_load, .door_fb, .hold_time_ds, .mode, .door, .drive, .ovl, .dir_up,
    .car_call_lamp, .hall_up_lamp, .hall_dn_lamp);
  elv_door_model door_op (.clk_sys, .rstn, .door, .edge_hit, .door_fb);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // bounded wait on door.open (0), door.close (1) or drive.up (2)
  task automatic wait_for(input int id, input logic lvl, output int k);
    logic s;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
      s = (id == 0) ? door.open : (id == 1) ? door.close : drive.up;
    end while (s !== lvl && k < 300);
    if (s !== lvl) begin
      mismatches++;
      $display("[ERR] wait %0d expected %0h seen %0h", id, lvl, s);
      print_verdict();
    end
  endtask

  task automatic arrive(input logic [2:0] fl);
    @(posedge clk_sys);
    level_zone <= 1'b0;
    @(posedge clk_sys);
    current_floor <= fl;
    @(posedge clk_sys);
    level_zone <= 1'b1;
  endtask

  task automatic t_power();
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk("pwr_open", door.open, 1'b1);
    chk("mode_auto", mode, ELV_MODE_AUTO);
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b1, n);
    chk("hold_t", (n >= 12 && n <= 18), 1'b1);
    wait_for(1, 1'b0, n);
  endtask

  task automatic t_call();
    @(posedge clk_sys);
    car_btn <= 8'h08;
    hall_up_btn <= 8'h08;
    @(posedge clk_sys);
    car_btn <= 8'h00;
    hall_up_btn <= 8'h00;
    @(negedge clk_sys);
    chk("car_latch", car_call_lamp[3], 1'b1);
    wait_for(2, 1'b1, n);
    arrive(3'h3);
    wait_for(0, 1'b1, n);
    chk("stop_open", n <= 3, 1'b1);
    chk("stop_drive", drive.up, 1'b0);
    chk("car_served", car_call_lamp[3], 1'b0);
    chk("hall_served", hall_up_lamp[3], 1'b0);
    wait_for(0, 1'b0, n);
    // landing plus car call: T+2s is 24 ticks, far past plain T
    repeat (40) @(negedge clk_sys);
    chk("hold_long", door.close, 1'b0);
    @(posedge clk_sys);
    close_btn <= 1'b1;
    @(posedge clk_sys);
    close_btn <= 1'b0;
    @(negedge clk_sys);
    chk("close_btn", door.close, 1'b1);
    wait_for(1, 1'b0, n);
  endtask

  task automatic t_full();
    @(posedge clk_sys);
    full_load <= 1'b1;
    hall_up_btn <= 8'h20;
    hold_time_ds <= 8'h18;
    @(posedge clk_sys);
    hall_up_btn <= 8'h00;
    repeat (10) @(negedge clk_sys);
    chk("full_latch", hall_up_lamp[5], 1'b1);
    chk("full_still", drive.up, 1'b0);
    @(posedge clk_sys);
    full_load <= 1'b0;
    wait_for(2, 1'b1, n);
    chk("full_resume", n <= 3, 1'b1);
    @(posedge clk_sys);
    car_btn <= 8'h02;
    @(posedge clk_sys);
    car_btn <= 8'h00;
    repeat (3) @(negedge clk_sys);
    chk("wrong_call", car_call_lamp[1], 1'b0);
    arrive(3'h5);
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b1, n);
    // T-2s is 4 ticks of 4 cycles, plain T would be 96 cycles
    chk("hold_short", n >= 10 && n <= 20, 1'b1);
    wait_for(1, 1'b0, n);
  endtask

  task automatic t_ovl();
    @(posedge clk_sys);
    overload <= 1'b1;
    hold_time_ds <= 8'h04;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("ovl_out", ovl, 3'h7);
    wait_for(0, 1'b1, n);
    chk("ovl_drive", drive, 3'h0);
    @(posedge clk_sys);
    overload <= 1'b0;
    wait_for(1, 1'b1, n);
    @(posedge clk_sys);
    edge_hit <= 1'b1;
    wait_for(0, 1'b1, n);
    chk("edge_rev", n <= 4, 1'b1);
    @(posedge clk_sys);
    edge_hit <= 1'b0;
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
  endtask

  task automatic t_att();
    @(posedge clk_sys);
    sel <= 4'hF;
    @(posedge clk_sys);
    hall_dn_btn <= 8'h20;
    @(posedge clk_sys);
    hall_dn_btn <= 8'h00;
    chk("mode_att", mode, ELV_MODE_ATTEND);
    wait_for(0, 1'b1, n);
    chk("hall_reopen", n <= 3, 1'b1);
    wait_for(0, 1'b0, n);
    repeat (40) @(negedge clk_sys);
    chk("att_no_close", door.close, 1'b0);
    @(posedge clk_sys);
    close_btn <= 1'b1;
    wait_for(1, 1'b1, n);
    @(posedge clk_sys);
    close_btn <= 1'b0;
    wait_for(1, 1'b0, n);
  endtask

  task automatic t_byp();
    @(posedge clk_sys);
    bypass_btn <= 1'b1;
    hall_dn_btn <= 8'h80;
    @(posedge clk_sys);
    hall_dn_btn <= 8'h00;
    repeat (5) @(negedge clk_sys);
    chk("byp_latch", hall_dn_lamp[7], 1'b1);
    chk("byp_still", drive.up, 1'b0);
    @(posedge clk_sys);
    bypass_btn <= 1'b0;
    wait_for(2, 1'b1, n);
    chk("byp_resume", n <= 3, 1'b1);
    chk("run_dir", dir_up, 1'b1);
    arrive(3'h7);
    wait_for(0, 1'b1, n);
    chk("term_stop", n <= 3, 1'b1);
    chk("term_served", hall_dn_lamp[7], 1'b0);
    wait_for(0, 1'b0, n);
    @(posedge clk_sys);
    close_btn <= 1'b1;
    wait_for(1, 1'b1, n);
    @(posedge clk_sys);
    close_btn <= 1'b0;
    wait_for(1, 1'b0, n);
  endtask

  task automatic t_insp();
    @(posedge clk_sys);
    sel <= 4'h6;
    insp <= 6'h20;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("mode_insp", mode, ELV_MODE_INSP);
    chk("insp_run", drive, 3'h5);
    @(posedge clk_sys);
    insp <= 6'h00;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("insp_stop", drive.up, 1'b0);
    @(posedge clk_sys);
    sel <= 4'hE;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_power();
    t_call();
    t_full();
    t_ovl();
    t_att();
    t_byp();
    t_insp();
    print_verdict();
  end
endmodule // testbench
